// ==== mme_map.svh ====
// Purpose: named constants for monitor entry and the monitor serial link
// Assumes: 100 MHz system clock
// Notes:   figures are kept as printed; cycle counts derive from them
`ifndef MME_MAP_SVH
`define MME_MAP_SVH

`define MME_CLK_HZ        32'h05F5_E100
`define MME_BUS_EXT_HZ    32'h0025_8000
`define MME_BUS_INT_HZ    32'h000F_4240
`define MME_BAUD_DIV_EXT  16'h0100
`define MME_BAUD_DIV_INT  16'h00CE
`define MME_SEC_BYTES     4'h8
`define MME_BREAK_BITS    4'hA
`define MME_FRAME_BITS    4'hA
`define MME_DATA_BITS     4'h8
`define MME_VEC_ERASED    16'hFFFF
`define MME_TRIM_ERASED   8'hFF
`define MME_TRIM_DEFAULT  8'h80
`define MME_SYNC_RST      7'h01

`endif

// ==== mme_pkg.sv ====
// Purpose: shared types for monitor entry
// Assumes: nothing
// Notes:   constants live in mme_map.svh
package mme_pkg;

    typedef enum logic [1:0] {
        MODE_USER       = 2'h0,
        MODE_NORMAL     = 2'h1,
        MODE_FORCED_EXT = 2'h2,
        MODE_FORCED_INT = 2'h3
    } mon_mode_type;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0001,
        ST_SECURITY = 4'b0010,
        ST_BREAK    = 4'b0100,
        ST_READY    = 4'b1000
    } link_state_type;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } rx_state_type;

endpackage : mme_pkg

// ==== mon_link_if.sv ====
// Purpose: carries character requests and received bytes between control and engine
// Assumes: single clock domain
// Notes:   tx_req is a one-cycle pulse, honoured only while tx_busy is low
`timescale 1ns/1ps
interface mon_link_if;
    logic [15:0] bit_cycles;
    logic        tx_req;
    logic        tx_break;
    logic [7:0]  tx_byte;
    logic        tx_busy;
    logic        rx_valid;
    logic [7:0]  rx_byte;

    modport ctrl (
        output bit_cycles, tx_req, tx_break, tx_byte,
        input  tx_busy, rx_valid, rx_byte
    );
    modport engine (
        input  bit_cycles, tx_req, tx_break, tx_byte,
        output tx_busy, rx_valid, rx_byte
    );
endinterface : mon_link_if

// ==== mon_serial_engine.sv ====
// Purpose: half-duplex nrz character engine on the wired-or monitor line
// Assumes: line_i already synchronised; bit_cycles stable while in use
// Notes:   the line is only ever pulled low; the pullup makes every one
`timescale 1ns/1ps
`include "mme_map.svh"
module mon_serial_engine (
    input  wire logic       clk_sys_i,
    input  wire logic       resetn_i,
    input  wire logic       line_i,
    output logic            tx_low_o,
    mon_link_if.engine      link
);
    import mme_pkg::*;

    rx_state_type rx_state_q;
    logic [15:0]  rx_cnt_q;
    logic [3:0]   rx_bits_q;
    logic [7:0]   rx_sh_q;
    logic [9:0]   tx_sh_q;
    logic [3:0]   tx_bits_q;
    logic [15:0]  tx_cnt_q;

    // receive, sampled near mid-bit; own transmission is not heard back
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_state_q    <= RX_IDLE;
            rx_cnt_q      <= 16'h0000;
            rx_bits_q     <= 4'h0;
            rx_sh_q       <= 8'h00;
            link.rx_valid <= 1'b0;
            link.rx_byte  <= 8'h00;
        end else begin
            link.rx_valid <= 1'b0;
            case (rx_state_q)
                RX_IDLE: begin
                    if (!line_i && !link.tx_busy) begin
                        rx_cnt_q   <= link.bit_cycles >> 1;
                        rx_state_q <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt_q != 16'h0000) begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end else if (!line_i) begin
                        rx_cnt_q   <= link.bit_cycles - 16'h0001;
                        rx_bits_q  <= 4'h0;
                        rx_state_q <= RX_DATA;
                    end else begin
                        rx_state_q <= RX_IDLE; // glitch, not a start bit
                    end
                end
                RX_DATA: begin
                    if (rx_cnt_q != 16'h0000) begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end else begin
                        rx_sh_q  <= {line_i, rx_sh_q[7:1]};
                        rx_cnt_q <= link.bit_cycles - 16'h0001;
                        if (rx_bits_q == `MME_DATA_BITS - 4'h1) begin
                            rx_state_q <= RX_STOP;
                        end else begin
                            rx_bits_q <= rx_bits_q + 4'h1;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_cnt_q != 16'h0000) begin
                        rx_cnt_q <= rx_cnt_q - 16'h0001;
                    end else begin
                        rx_state_q <= RX_IDLE;
                        if (line_i) begin
                            link.rx_valid <= 1'b1;
                            link.rx_byte  <= rx_sh_q;
                        end
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    // transmit: byte frame or all-zero break, lsb first
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_sh_q      <= 10'h000;
            tx_bits_q    <= 4'h0;
            tx_cnt_q     <= 16'h0000;
            tx_low_o     <= 1'b0;
            link.tx_busy <= 1'b0;
        end else if (!link.tx_busy) begin
            if (link.tx_req) begin
                tx_sh_q      <= link.tx_break ? 10'h000 : {1'b1, link.tx_byte, 1'b0};
                tx_bits_q    <= `MME_FRAME_BITS;
                tx_cnt_q     <= link.bit_cycles - 16'h0001;
                tx_low_o     <= 1'b1;
                link.tx_busy <= 1'b1;
            end
        end else if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
        end else if (tx_bits_q == 4'h1) begin
            tx_low_o     <= 1'b0;
            link.tx_busy <= 1'b0;
        end else begin
            tx_sh_q   <= tx_sh_q >> 1;
            tx_low_o  <= !tx_sh_q[1];
            tx_bits_q <= tx_bits_q - 4'h1;
            tx_cnt_q  <= link.bit_cycles - 16'h0001;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_start_bit_low: assert property (link.tx_req && !link.tx_busy |=> tx_low_o && link.tx_busy)
        else $error("character did not open with a low start bit");
    a_idle_released: assert property (!link.tx_busy |-> !tx_low_o)
        else $error("line pulled low outside a character");

endmodule : mon_serial_engine

// ==== monitor_mode_entry.sv ====
// Purpose: monitor mode entry selection and host link start-up
// Assumes: pins arrive asynchronously; vector and trim come from flash, same clock
// Notes:   selection is taken on the rising edge of the internal reset
//
// Summary of operation
// - monitor traffic uses only the serial pin
// - serial pin is wired-or, only pulled low
// - low interrupt pin with erased vector and no test voltage enables trimmed internal oscillator
// - programmed vector blocks entry without test voltage
// - test voltage entry uses external clock, 9600 baud
// - erased vector, high interrupt pin: external clock
// - erased vector, low interrupt pin: internal oscillator
// - mode captured on internal reset rising edge
// - baud is bus/256 external, bus/206 internal
// - wait for eight security bytes first
// - then send ten-zero break, ready for command
// - watchdog disabled in forced monitor mode
// - same baud rate for transmit and receive
`timescale 1ns/1ps
`include "mme_map.svh"
module monitor_mode_entry #(
    parameter int unsigned BIT_CYC_EXT = int'((64'(`MME_CLK_HZ) * 64'(`MME_BAUD_DIV_EXT))
                                              / 64'(`MME_BUS_EXT_HZ)),
    parameter int unsigned BIT_CYC_INT = int'((64'(`MME_CLK_HZ) * 64'(`MME_BAUD_DIV_INT))
                                              / 64'(`MME_BUS_INT_HZ))
) (
    input  wire logic          clk_sys_i,
    input  wire logic          resetn_i,
    input  wire logic          internal_reset_n_i,
    input  wire logic          power_on_reset_i,
    input  wire logic          interrupt_request_pin_i,
    input  wire logic          high_test_voltage_i,
    input  wire logic          mode_select_a_pin_i,
    input  wire logic          mode_select_b_pin_i,
    input  wire logic          serial_comm_pin_i,
    input  wire logic [15:0]   reset_vector_i,
    input  wire logic [7:0]    oscillator_trim_value_i,
    output logic               serial_comm_pin_o,
    output logic               serial_comm_pin_oe_o,
    output mme_pkg::mon_mode_type mon_mode_o,
    output logic               monitor_mode_o,
    output logic               forced_mode_o,
    output logic               internal_osc_en_o,
    output logic [7:0]         osc_trim_o,
    output logic               watchdog_disable_o,
    output logic               link_ready_o,
    output logic [7:0]         rx_byte_o,
    output logic               rx_valid_o
);
    import mme_pkg::*;

    localparam int SYNC_W = 7;
    localparam logic [SYNC_W-1:0] SYNC_RST = `MME_SYNC_RST;

    // pin order in the synchroniser vector
    localparam int S_LINE = 0;
    localparam int S_SELB = 1;
    localparam int S_SELA = 2;
    localparam int S_HIGH_TEST_VOLTAGE = 3;
    localparam int S_IRQ  = 4;
    localparam int S_POR  = 5;
    localparam int S_RSTN = 6;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic              rstn_dly_q;
    logic              reset_rise;
    logic              vec_blank;
    logic              trim_prog;
    mon_mode_type      mode_d;
    link_state_type    state_q;
    logic [3:0]        sec_cnt_q;
    logic [15:0]       bit_cycles_q;
    logic              tx_req_q;
    logic              tx_low;
    logic              vec_blank_q;
    logic [19:0]       low_run_q;

    mon_link_if link ();

    assign pins_raw = {internal_reset_n_i, power_on_reset_i, interrupt_request_pin_i,
                       high_test_voltage_i, mode_select_a_pin_i, mode_select_b_pin_i,
                       serial_comm_pin_i};

    // two flops per pin; the first is read by the second only
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_sync
            always_ff @(posedge clk_sys_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    sync1_q[g] <= SYNC_RST[g];
                    sync2_q[g] <= SYNC_RST[g];
                end else begin
                    sync1_q[g] <= pins_raw[g];
                    sync2_q[g] <= sync1_q[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rstn_dly_q <= 1'b0;
        end else begin
            rstn_dly_q <= sync2_q[S_RSTN];
        end
    end

    assign reset_rise = sync2_q[S_RSTN] && !rstn_dly_q;
    assign vec_blank  = (reset_vector_i == `MME_VEC_ERASED);
    assign trim_prog  = (oscillator_trim_value_i != `MME_TRIM_ERASED);

    // entry decision from the sampled pins and the vector
    always_comb begin
        mode_d = MODE_USER;
        if (!sync2_q[S_POR] && (mon_mode_o == MODE_FORCED_EXT || mon_mode_o == MODE_FORCED_INT)) begin
            mode_d = mon_mode_o; // only power-on reset leaves forced mode
        end else if (sync2_q[S_HIGH_TEST_VOLTAGE]) begin
            if (sync2_q[S_SELA] && !sync2_q[S_SELB] && sync2_q[S_LINE]) begin
                mode_d = MODE_NORMAL;
            end
        end else if (vec_blank) begin
            mode_d = sync2_q[S_IRQ] ? MODE_FORCED_EXT : MODE_FORCED_INT;
        end
    end

    // mode held between reset edges so select pins may move freely
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mon_mode_o        <= MODE_USER;
            monitor_mode_o    <= 1'b0;
            forced_mode_o     <= 1'b0;
            internal_osc_en_o <= 1'b0;
            osc_trim_o        <= `MME_TRIM_DEFAULT;
            vec_blank_q       <= 1'b0;
        end else if (reset_rise) begin
            mon_mode_o        <= mode_d;
            monitor_mode_o    <= (mode_d != MODE_USER);
            forced_mode_o     <= (mode_d == MODE_FORCED_EXT) || (mode_d == MODE_FORCED_INT);
            internal_osc_en_o <= (mode_d == MODE_FORCED_INT);
            osc_trim_o        <= trim_prog ? oscillator_trim_value_i : `MME_TRIM_DEFAULT;
            vec_blank_q       <= vec_blank;
        end
    end

    // bit period follows the clock source; one value serves both directions
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bit_cycles_q <= 16'(BIT_CYC_EXT);
        end else if (reset_rise) begin
            bit_cycles_q <= (mode_d == MODE_FORCED_INT) ? 16'(BIT_CYC_INT) : 16'(BIT_CYC_EXT);
        end
    end

    // forced mode always; normal mode while test voltage stays applied
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            watchdog_disable_o <= 1'b0;
        end else begin
            watchdog_disable_o <= forced_mode_o || (mon_mode_o == MODE_NORMAL && sync2_q[S_HIGH_TEST_VOLTAGE]);
        end
    end

    // link start-up: security bytes, then break, then ready
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q   <= ST_IDLE;
            sec_cnt_q <= 4'h0;
            tx_req_q  <= 1'b0;
        end else begin
            tx_req_q <= 1'b0;
            if (!sync2_q[S_RSTN]) begin
                state_q <= ST_IDLE;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (reset_rise && mode_d != MODE_USER) begin
                            state_q   <= ST_SECURITY;
                            sec_cnt_q <= 4'h0;
                        end
                    end
                    ST_SECURITY: begin
                        if (link.rx_valid) begin
                            if (sec_cnt_q == `MME_SEC_BYTES - 4'h1) begin
                                state_q  <= ST_BREAK;
                                tx_req_q <= 1'b1;
                            end
                            sec_cnt_q <= sec_cnt_q + 4'h1;
                        end
                    end
                    ST_BREAK: begin
                        if (!tx_req_q && !link.tx_busy) begin
                            state_q <= ST_READY;
                        end
                    end
                    ST_READY: begin
                        // a released interrupt pin drops the internal clock session
                        if (mon_mode_o == MODE_FORCED_INT && sync2_q[S_IRQ]) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            link_ready_o <= 1'b0;
            rx_valid_o   <= 1'b0;
            rx_byte_o    <= 8'h00;
        end else begin
            link_ready_o <= (state_q == ST_READY);
            rx_valid_o   <= (state_q == ST_READY) && link.rx_valid;
            rx_byte_o    <= link.rx_valid ? link.rx_byte : rx_byte_o;
        end
    end

    assign link.bit_cycles = bit_cycles_q;
    assign link.tx_req     = tx_req_q;
    assign link.tx_break   = 1'b1; // only the break is sent from here
    assign link.tx_byte    = 8'h00;

    mon_serial_engine u_engine (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .line_i    (sync2_q[S_LINE]),
        .tx_low_o  (tx_low),
        .link      (link)
    );

    // pin only ever driven to zero; pullup restores the idle level
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_comm_pin_o    <= 1'b0;
            serial_comm_pin_oe_o <= 1'b0;
        end else begin
            serial_comm_pin_o    <= 1'b0;
            serial_comm_pin_oe_o <= tx_low && monitor_mode_o;
        end
    end

    // helper: length of the current low drive
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_run_q <= 20'h0_0000;
        end else if (serial_comm_pin_oe_o) begin
            low_run_q <= low_run_q + 20'h0_0001;
        end else begin
            low_run_q <= 20'h0_0000;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    a_pin_never_high: assert property (serial_comm_pin_o == 1'b0)
        else $error("serial pin driven high");
    a_drive_only_tx: assert property (serial_comm_pin_oe_o |-> $past(link.tx_busy) && monitor_mode_o)
        else $error("serial pin driven outside a monitor character");
    a_no_int_programmed: assert property (internal_osc_en_o |-> vec_blank_q && forced_mode_o)
        else $error("internal oscillator entry with programmed vector");
    a_latch_on_edge: assert property (reset_rise |=> mon_mode_o == $past(mode_d))
        else $error("mode not captured on reset release");
    a_mode_held: assert property (!reset_rise |=> $stable(mon_mode_o))
        else $error("mode changed without a reset edge");
    a_ext_normal: assert property (mon_mode_o == MODE_NORMAL |-> !internal_osc_en_o
                                   && bit_cycles_q == 16'(BIT_CYC_EXT))
        else $error("normal monitor not on external clock rate");
    a_forced_ext: assert property (mon_mode_o == MODE_FORCED_EXT |-> !internal_osc_en_o)
        else $error("forced external entry selected internal oscillator");
    a_int_rate: assert property (internal_osc_en_o |-> bit_cycles_q == 16'(BIT_CYC_INT))
        else $error("internal oscillator with wrong bit period");
    a_trim_used: assert property ($rose(internal_osc_en_o) && $past(trim_prog)
                                  |-> osc_trim_o == $past(oscillator_trim_value_i))
        else $error("programmed trim not applied");
    a_wdog_forced: assert property (forced_mode_o |=> watchdog_disable_o)
        else $error("watchdog running in forced monitor mode");
    a_sec_before_break: assert property ($rose(state_q == ST_BREAK) |-> $past(sec_cnt_q) == 4'h7
                                         && $past(link.rx_valid))
        else $error("break before eight security bytes");
    // state has already moved to ready when the drop is seen, so look one cycle back
    a_break_length: assert property ($fell(serial_comm_pin_oe_o) && $past(state_q == ST_BREAK)
                                     |-> low_run_q == 20'(bit_cycles_q) * 20'(`MME_BREAK_BITS))
        else $error("break is not ten bit times low");

    c_ready_int: cover property (link_ready_o && internal_osc_en_o);
    c_ready_ext: cover property (link_ready_o && mon_mode_o == MODE_FORCED_EXT);
    c_ready_normal: cover property (link_ready_o && mon_mode_o == MODE_NORMAL);
    c_cmd_byte: cover property (rx_valid_o);

endmodule : monitor_mode_entry

// ==== host_link_model.sv ====
// Purpose: host side of the single-wire monitor link
// Assumes: line_i is the resolved wired-or level
// Notes:   the host only ever pulls low; released means the pullup wins
`timescale 1ns/1ps
module host_link_model (
    input  wire logic clk_sys_i,
    input  wire logic line_i,
    output logic      host_oe_o
);
    initial begin
        host_oe_o = 1'b0;
    end

    // one nrz character, changed only at the falling edge
    task automatic send_byte(input logic [7:0] b, input int bc);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_sys_i);
            host_oe_o <= !f[i];
            repeat (bc - 1) @(negedge clk_sys_i);
        end
    endtask : send_byte
endmodule : host_link_model

// ==== monitor_mode_entry_tb_top.sv ====
// Purpose: self-checking bench for monitor entry and link start-up
// Assumes: short bit periods so a session fits in a few thousand cycles
// Notes:   line resolved from both pull-down enables and the pullup
`timescale 1ns/1ps
module monitor_mode_entry_tb_top;
    import mme_pkg::*;
    localparam int BCE = 16;
    localparam int BCI = 20;
    logic         clk_sys_i = 1'b0;
    logic         resetn_i  = 1'b0;
    logic         irst_n    = 1'b0;
    logic         irq       = 1'b1;
    logic         tv        = 1'b0;
    logic         sa        = 1'b0;
    logic         sb        = 1'b0;
    logic         por       = 1'b1;
    logic         oe_prev   = 1'b0;
    logic [15:0]  vec       = 16'hFFFF;
    logic         pin_o, dev_oe, mon, forced, osc_en, wd_dis, ready, rx_v;
    logic [7:0]   trim_o, rx_b, rx_seen;
    mon_mode_type mode;
    wire          host_oe;
    wire          line = !(dev_oe | host_oe);
    int           miscompares = 0;
    int           tests_run = 0;
    int           rx_cnt = 0;
    int           br_cnt = 0;
    int           run_len = 0;
    int           brk_len = 0;

    initial forever #5 clk_sys_i = !clk_sys_i;

    monitor_mode_entry #(.BIT_CYC_EXT(BCE), .BIT_CYC_INT(BCI)) u_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .internal_reset_n_i(irst_n),
        .power_on_reset_i(por), .interrupt_request_pin_i(irq), .high_test_voltage_i(tv),
        .mode_select_a_pin_i(sa), .mode_select_b_pin_i(sb), .serial_comm_pin_i(line),
        .reset_vector_i(vec), .oscillator_trim_value_i(8'h3C), .serial_comm_pin_o(pin_o),
        .serial_comm_pin_oe_o(dev_oe), .mon_mode_o(mode), .monitor_mode_o(mon),
        .forced_mode_o(forced), .internal_osc_en_o(osc_en), .osc_trim_o(trim_o),
        .watchdog_disable_o(wd_dis), .link_ready_o(ready), .rx_byte_o(rx_b), .rx_valid_o(rx_v)
    );

    host_link_model u_host (.clk_sys_i(clk_sys_i), .line_i(line), .host_oe_o(host_oe));

    always @(posedge clk_sys_i) begin
        if (rx_v === 1'b1) begin
            rx_seen <= rx_b;
            rx_cnt  <= rx_cnt + 1;
        end
        oe_prev <= dev_oe;
        if (dev_oe === 1'b1) begin
            run_len <= run_len + 1;
            if (oe_prev !== 1'b1) br_cnt <= br_cnt + 1;
        end else if (oe_prev === 1'b1) begin
            brk_len <= run_len;
            run_len <= 0;
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // pins set while internal reset is low, latched at its rise
    task automatic enter(input logic i, input logic t, input logic a, input logic b, input logic [15:0] v);
        @(negedge clk_sys_i);
        irst_n = 1'b0;
        {irq, tv, sa, sb, vec} = {i, t, a, b, v};
        repeat (5) @(negedge clk_sys_i);
        irst_n = 1'b1;
        repeat (6) @(negedge clk_sys_i);
    endtask : enter

    task automatic expect_mode(input mon_mode_type m, input logic f, input logic o, input logic w);
        check("mon_mode", 16'(mode), 16'(m));
        check("forced", 16'(forced), 16'(f));
        check("osc_en", 16'(osc_en), 16'(o));
        check("wd_dis", 16'(wd_dis), 16'(w));
    endtask : expect_mode

    // eight security bytes, break, then one command byte
    task automatic session(input int bc);
        int b0;
        int r0;
        int n;
        b0 = br_cnt;
        r0 = rx_cnt;
        for (int k = 0; k < 7; k++) u_host.send_byte(8'(k * 37), bc);
        check("quiet_during_security", 16'(br_cnt), 16'(b0));
        u_host.send_byte(8'hFF, bc);
        // break may start before the host's stop bit ends; its length is measured by the monitor
        n = 0;
        while (ready !== 1'b1 && n < 20 * bc) begin
            @(negedge clk_sys_i);
            n++;
        end
        check("break_count", 16'(br_cnt), 16'(b0 + 1));
        check("break_cycles", 16'(brk_len), 16'(10 * bc));
        check("pin_level", 16'(pin_o), 16'h0000);
        check("rx_before_ready", 16'(rx_cnt), 16'(r0));
        repeat (6) @(negedge clk_sys_i);
        check("link_ready", 16'(ready), 16'h0001);
        u_host.send_byte(8'hA5, bc);
        repeat (4) @(negedge clk_sys_i);
        check("rx_count", 16'(rx_cnt), 16'(r0 + 1));
        check("rx_byte", 16'(rx_seen), 16'h00A5);
    endtask : session

    task automatic t_reset();
        check("mode_at_reset", 16'(mode), 16'(MODE_USER));
        check("trim_at_reset", 16'(trim_o), 16'h0080);
        check("oe_at_reset", 16'(dev_oe), 16'h0000);
    endtask : t_reset

    task automatic t_normal();
        enter(1'b1, 1'b1, 1'b1, 1'b0, 16'h1234);
        expect_mode(MODE_NORMAL, 1'b0, 1'b0, 1'b1);
        check("monitor", 16'(mon), 16'h0001);
        {sa, sb} = 2'b01;
        repeat (10) @(negedge clk_sys_i);
        check("mode_after_pins", 16'(mode), 16'(MODE_NORMAL));
        session(BCE);
    endtask : t_normal

    task automatic t_refuse();
        enter(1'b1, 1'b1, 1'b0, 1'b0, 16'h1234);
        check("bad_select", 16'(mode), 16'(MODE_USER));
        enter(1'b0, 1'b0, 1'b1, 1'b0, 16'h1234);
        check("prog_vector", 16'(mode), 16'(MODE_USER));
        u_host.send_byte(8'h00, BCE);
        repeat (40) @(negedge clk_sys_i);
        check("user_silent", 16'(dev_oe), 16'h0000);
    endtask : t_refuse

    task automatic t_forced();
        enter(1'b1, 1'b0, 1'b0, 1'b1, 16'hFFFF);
        expect_mode(MODE_FORCED_EXT, 1'b1, 1'b0, 1'b1);
        enter(1'b0, 1'b0, 1'b0, 1'b0, 16'hFFFF);
        expect_mode(MODE_FORCED_INT, 1'b1, 1'b1, 1'b1);
        check("trim", 16'(trim_o), 16'h003C);
        session(BCI);
        irq = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        check("session_lost", 16'(ready), 16'h0000);
        por = 1'b0;
        enter(1'b1, 1'b0, 1'b0, 1'b0, 16'hFFFF);
        expect_mode(MODE_FORCED_INT, 1'b1, 1'b1, 1'b1);
    endtask : t_forced

    initial begin
        #300_000;
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (20) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        @(negedge clk_sys_i);
        t_reset();
        t_normal();
        t_refuse();
        t_forced();
        finish_test();
    end
endmodule : monitor_mode_entry_tb_top
